//--- core/flash_blank_check_addr_status.sv
`timescale 1ns/1ns
// Notes on behaviour
// - A 32-bit register holds the blank-check end address.
// - An inconsistent range at blank-check start flags an error and locks commands.
// - End address resets on reset and on a setup-initialise write of 1.
// - Blank check uses only end-address bits 18 down to 2.
// - Status bits 31 to 19 always read their reset value.
// - Status bit 18 shows the ECC buffer full; set on fill, cleared when emptied.
// - Dummy ECC writes while the buffer is full stall the bus with wait states.
// - With ECC disabled, the dummy ECC register acts as the ECC buffer.
// - Status bit 17 flags an OTP double error and holds the command lock.
// - The OTP value is checked during the OTP-reading command group.
// - Status bit 16 flags a corrected OTP single error; no lock follows.
// - Both OTP flags clear when status-clear or forced-stop processing begins.
// - A 32-bit start-address register gives the beginning of the target range.
// - Status bit 15 reads 0 while a command runs, 1 when idle.
module flash_blank_check_addr_status (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire flash_seq_pkg::bus_req_t i_bus,
  input  wire flash_seq_pkg::seq_evt_t i_evt,
  input  wire logic                    i_seq_busy,
  output logic                         o_bus_ack,
  output logic [31:0]                  o_bus_rdata,
  output logic                         o_cmd_lock,
  output logic                         o_bc_error,
  output logic [31:0]                  o_bc_start_addr,
  output logic [31:0]                  o_bc_end_addr,
  output logic                         o_bc_descending,
  output logic                         o_ecc_buffer_full,
  output logic [31:0]                  o_ecc_word
);
  import flash_seq_pkg::*;

  // ---------------------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    SEQ_OPEN   = 1'b0,
    SEQ_LOCKED = 1'b1
  } lock_state_t;

  // Keeps only the bits blank check walks over; the rest read as zero.
  function automatic logic [31:0] bc_mask(input logic [31:0] addr);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[BC_ADDR_HI:BC_ADDR_LO] = addr[BC_ADDR_HI:BC_ADDR_LO];
    return m;
  endfunction : bc_mask

  function automatic logic hit(input bus_req_t b, input logic [3:0] idx);
    return b.addr == idx;
  endfunction : hit

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0]  start_addr_r;
  logic [31:0]  start_addr_nxt;
  logic [31:0]  end_addr_r;
  logic [31:0]  end_addr_nxt;
  logic         bc_dir_r;
  logic         bc_dir_nxt;
  logic         ecc_disable_r;
  logic         ecc_disable_nxt;
  lock_state_t  lock_r;
  lock_state_t  lock_nxt;
  logic         ack_r;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;
  logic         bc_err_r;
  logic         bc_err_nxt;
  logic         cmd_lock_r;
  logic [31:0]  bc_start_r;
  logic [31:0]  bc_end_r;
  logic         bc_desc_r;
  logic         ecc_full_out_r;
  logic [31:0]  ecc_word_out_r;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic        ecc_full;
  wire logic [31:0] ecc_word;
  wire logic        otp_double;
  wire logic        otp_single;

  // The dummy ECC write is held off rather than dropped, so software can
  // stream ECC words without polling the full flag.
  wire logic stall     = i_bus.wr && hit(i_bus, REG_DUMMY_ECC) && ecc_full;
  wire logic accept    = i_bus.req && !ack_r && !stall;
  wire logic wr_take   = accept && i_bus.wr;
  wire logic rd_take   = accept && !i_bus.wr;
  wire logic wr_start  = wr_take && hit(i_bus, REG_START_ADDR);
  wire logic wr_end    = wr_take && hit(i_bus, REG_END_ADDR);
  wire logic wr_ctrl   = wr_take && hit(i_bus, REG_BC_CTRL);
  wire logic wr_setup  = wr_take && hit(i_bus, REG_SETUP_INIT);
  wire logic wr_ecct   = wr_take && hit(i_bus, REG_ECC_TEST);
  wire logic wr_dummy  = wr_take && hit(i_bus, REG_DUMMY_ECC);
  wire logic setup_one = wr_setup && i_bus.wdata[SETUP_INIT_BIT];
  wire logic clr_cmd   = i_evt.status_clear_start || i_evt.forced_stop_start;
  wire logic dbl_seen  = i_evt.otp_read_done && i_evt.otp_cmd && i_evt.otp_double_err;
  // Next value of the double-error flag, so the lock drops in the clearing cycle.
  wire logic dbl_next  = dbl_seen || (otp_double && !clr_cmd);

  // ---------------------------------------------------------------------------
  // Address registers
  // ---------------------------------------------------------------------------
  assign start_addr_nxt = setup_one ? ADDR_RESET :
                          wr_start  ? i_bus.wdata : start_addr_r;
  assign end_addr_nxt   = setup_one ? ADDR_RESET :
                          wr_end    ? i_bus.wdata : end_addr_r;
  assign bc_dir_nxt      = wr_ctrl ? i_bus.wdata[BC_DIR_BIT] : bc_dir_r;
  assign ecc_disable_nxt = wr_ecct ? i_bus.wdata[ECC_DISABLE_BIT] : ecc_disable_r;

  // ---------------------------------------------------------------------------
  // Blank-check range check
  // ---------------------------------------------------------------------------
  wire logic [31:0] start_used = bc_mask(start_addr_r);
  wire logic [31:0] end_used   = bc_mask(end_addr_r);
  // Software is expected to keep the range ordered; this catches it when not.
  wire logic range_bad = bc_dir_r ? (start_used < end_used)
                                  : (start_used > end_used);
  wire logic bc_fault  = i_evt.blank_check_start && range_bad;

  assign bc_err_nxt = bc_fault;

  // A new fault wins over a clear arriving in the same cycle.
  always_comb begin
    lock_nxt = lock_r;
    unique case (lock_r)
      SEQ_OPEN: begin
        if (bc_fault) begin
          lock_nxt = SEQ_LOCKED;
        end
      end
      SEQ_LOCKED: begin
        if (clr_cmd && !bc_fault) begin
          lock_nxt = SEQ_OPEN;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------------
  ecc_buffer u_ecc_buffer (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_write     (wr_dummy),
    .i_as_buffer (ecc_disable_r),
    .i_wdata     (i_bus.wdata),
    .i_consume   (i_evt.ecc_consume),
    .o_full      (ecc_full),
    .o_word      (ecc_word)
  );

  otp_monitor u_otp_monitor (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_check       (i_evt.otp_read_done && i_evt.otp_cmd),
    .i_double_err  (i_evt.otp_double_err),
    .i_single_corr (i_evt.otp_single_corr),
    .i_clear       (clr_cmd),
    .o_double      (otp_double),
    .o_single      (otp_single)
  );

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  wire logic [31:0] status_word = {STAT_RSVD_RESET,
                                   ecc_full,
                                   otp_double,
                                   otp_single,
                                   !i_seq_busy,
                                   STAT_LOW_RESET};

  wire logic [31:0] rd_mux =
    hit(i_bus, REG_START_ADDR) ? start_addr_r :
    hit(i_bus, REG_END_ADDR)   ? end_addr_r :
    hit(i_bus, REG_BC_CTRL)    ? {31'h0000_0000, bc_dir_r} :
    hit(i_bus, REG_STATUS)     ? status_word :
    hit(i_bus, REG_ECC_TEST)   ? {31'h0000_0000, ecc_disable_r} :
    hit(i_bus, REG_DUMMY_ECC)  ? ecc_word : REG_RESET;

  assign rdata_nxt = rd_take ? rd_mux : REG_RESET;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      start_addr_r  <= ADDR_RESET;
      end_addr_r    <= ADDR_RESET;
      bc_dir_r      <= 1'b0;
      ecc_disable_r <= 1'b0;
      lock_r        <= SEQ_OPEN;
    end else begin
      start_addr_r  <= start_addr_nxt;
      end_addr_r    <= end_addr_nxt;
      bc_dir_r      <= bc_dir_nxt;
      ecc_disable_r <= ecc_disable_nxt;
      lock_r        <= lock_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= REG_RESET;
      bc_err_r <= 1'b0;
    end else begin
      ack_r    <= accept;
      rdata_r  <= rdata_nxt;
      bc_err_r <= bc_err_nxt;
    end
  end

  // Outputs are registered copies so downstream timing starts at a flop.
  // The lock output tracks the double-error flag in the same cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd_lock_r     <= 1'b0;
      bc_start_r     <= ADDR_RESET;
      bc_end_r       <= ADDR_RESET;
      bc_desc_r      <= 1'b0;
      ecc_full_out_r <= 1'b0;
      ecc_word_out_r <= REG_RESET;
    end else begin
      cmd_lock_r     <= (lock_nxt == SEQ_LOCKED) || dbl_next;
      bc_start_r     <= start_used;
      bc_end_r       <= end_used;
      bc_desc_r      <= bc_dir_r;
      ecc_full_out_r <= ecc_full;
      ecc_word_out_r <= ecc_word;
    end
  end

  assign o_bus_ack         = ack_r;
  assign o_bus_rdata       = rdata_r;
  assign o_cmd_lock        = cmd_lock_r;
  assign o_bc_error        = bc_err_r;
  assign o_bc_start_addr   = bc_start_r;
  assign o_bc_end_addr     = bc_end_r;
  assign o_bc_descending   = bc_desc_r;
  assign o_ecc_buffer_full = ecc_full_out_r;
  assign o_ecc_word        = ecc_word_out_r;

endmodule : flash_blank_check_addr_status

//--- include/flash_seq_pkg.sv
package flash_seq_pkg;

  // ---------------------------------------------------------------------------
  // Register indices on the peripheral register port
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_START_ADDR = 4'h0;
  localparam logic [3:0] REG_END_ADDR   = 4'h1;
  localparam logic [3:0] REG_BC_CTRL    = 4'h2;
  localparam logic [3:0] REG_SETUP_INIT = 4'h3;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_ECC_TEST   = 4'h5;
  localparam logic [3:0] REG_DUMMY_ECC  = 4'h6;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BC_DIR_BIT       = 0;
  localparam int SETUP_INIT_BIT   = 0;
  localparam int ECC_DISABLE_BIT  = 0;
  localparam int STAT_ECC_FULL    = 18;
  localparam int STAT_OTP_DOUBLE  = 17;
  localparam int STAT_OTP_SINGLE  = 16;
  localparam int STAT_READY       = 15;
  localparam int STAT_RSVD_HI     = 31;
  localparam int STAT_RSVD_LO     = 19;
  localparam int BC_ADDR_HI       = 18;
  localparam int BC_ADDR_LO       = 2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_RESET        = 32'h0000_0000;
  localparam logic [31:0] REG_RESET         = 32'h0000_0000;
  localparam logic [12:0] STAT_RSVD_RESET   = 13'h0000;
  localparam logic [14:0] STAT_LOW_RESET    = 15'h0000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic blank_check_start;
    logic status_clear_start;
    logic forced_stop_start;
    logic otp_read_done;
    logic otp_double_err;
    logic otp_single_corr;
    logic otp_cmd;
    logic ecc_consume;
  } seq_evt_t;

endpackage : flash_seq_pkg

//--- core/ecc_buffer.sv
`timescale 1ns/1ns
module ecc_buffer (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_write,
  input  wire logic        i_as_buffer,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_consume,
  output logic             o_full,
  output logic [31:0]      o_word
);
  import flash_seq_pkg::*;

  logic        full_r;
  logic        full_nxt;
  logic [31:0] word_r;

  // A fill in the same cycle as a drain wins, so no ECC word is lost.
  assign full_nxt = (i_write && i_as_buffer) ? 1'b1 :
                    i_consume               ? 1'b0 : full_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      full_r <= 1'b0;
      word_r <= REG_RESET;
    end else begin
      full_r <= full_nxt;
      if (i_write) begin
        word_r <= i_wdata;
      end
    end
  end

  assign o_full = full_r;
  assign o_word = word_r;

endmodule : ecc_buffer

//--- core/otp_monitor.sv
`timescale 1ns/1ns
module otp_monitor (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_check,
  input  wire logic i_double_err,
  input  wire logic i_single_corr,
  input  wire logic i_clear,
  output logic      o_double,
  output logic      o_single
);
  import flash_seq_pkg::*;

  logic dbl_r;
  logic sgl_r;
  logic dbl_nxt;
  logic sgl_nxt;

  // Set beats clear: a fault seen in the clearing cycle must survive.
  assign dbl_nxt = (i_check && i_double_err) ? 1'b1 : i_clear ? 1'b0 : dbl_r;
  assign sgl_nxt = (i_check && i_single_corr) ? 1'b1 : i_clear ? 1'b0 : sgl_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      dbl_r <= 1'b0;
      sgl_r <= 1'b0;
    end else begin
      dbl_r <= dbl_nxt;
      sgl_r <= sgl_nxt;
    end
  end

  assign o_double = dbl_r;
  assign o_single = sgl_r;

endmodule : otp_monitor

//--- verif/flash_bc_props.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------------
module flash_bc_props (
  input wire logic                    i_core_clk,
  input wire logic                    i_rst_n,
  input wire flash_seq_pkg::bus_req_t i_bus,
  input wire flash_seq_pkg::seq_evt_t i_evt,
  input wire logic                    i_seq_busy,
  input wire logic                    o_bus_ack,
  input wire logic [31:0]             o_bus_rdata,
  input wire logic                    o_cmd_lock,
  input wire logic                    o_bc_error,
  input wire logic [31:0]             o_bc_start_addr,
  input wire logic [31:0]             o_bc_end_addr,
  input wire logic                    o_bc_descending,
  input wire logic                    o_ecc_buffer_full,
  input wire logic [31:0]             o_ecc_word
);
  import flash_seq_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire bad_rng = o_bc_descending ? (o_bc_start_addr < o_bc_end_addr)
                                 : (o_bc_start_addr > o_bc_end_addr);
  wire stat_rd = i_bus.req && !i_bus.wr && i_bus.addr == REG_STATUS;
  wire ecc_wr  = i_bus.req && i_bus.wr && i_bus.addr == REG_DUMMY_ECC;
  wire otp_ok  = i_evt.otp_read_done && i_evt.otp_cmd;
  wire clr     = i_evt.status_clear_start || i_evt.forced_stop_start;
  wire init_wr = i_bus.req && i_bus.wr && i_bus.addr == REG_SETUP_INIT && i_bus.wdata[0];
  // A dummy write is left out here because a full buffer may hold it back.
  ack_latency_a: assert property (i_bus.req && !o_bus_ack && !ecc_wr |=> o_bus_ack)
    else $error("request not acknowledged in the next cycle");
  ecc_stall_a: assert property (ecc_wr && o_ecc_buffer_full && !$past(i_evt.ecc_consume)
    && !i_evt.ecc_consume |=> !o_bus_ack) else $error("write to a full buffer acknowledged");
  rsvd_zero_a: assert property ($past(stat_rd) && o_bus_ack |-> o_bus_rdata[31:19] == 13'h0000)
    else $error("reserved status bits not zero");
  ready_bit_a: assert property ($past(stat_rd) && o_bus_ack
    |-> o_bus_rdata[15] == !$past(i_seq_busy)) else $error("ready bit wrong");
  bad_range_a: assert property (i_evt.blank_check_start && bad_rng |=> o_bc_error && o_cmd_lock)
    else $error("bad range not flagged");
  good_range_a: assert property (i_evt.blank_check_start && !bad_rng |=> !o_bc_error)
    else $error("good range flagged");
  addr_mask_a: assert property (((o_bc_end_addr | o_bc_start_addr) & 32'hfff8_0003) == 32'h0)
    else $error("ignored address bits passed on");
  otp_lock_a: assert property (otp_ok && i_evt.otp_double_err |-> ##2 o_cmd_lock)
    else $error("double error did not lock");
  otp_clear_a: assert property (clr && !i_evt.blank_check_start && !i_evt.otp_read_done
    && !$past(i_evt.otp_read_done) && !$past(i_evt.otp_read_done, 2) |=> !o_cmd_lock)
    else $error("lock kept after clear");
  setup_init_a: assert property (init_wr && !o_bus_ack
    |-> ##[1:2] (o_bc_end_addr == 32'h0 && o_bc_start_addr == 32'h0)) else $error("init failed");
  cover property (i_evt.blank_check_start && bad_rng);
  cover property (ecc_wr && o_ecc_buffer_full);
  cover property (otp_ok && i_evt.otp_single_corr);
endmodule : flash_bc_props
bind flash_blank_check_addr_status flash_bc_props props_inst (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_bus(i_bus), .i_evt(i_evt), .i_seq_busy(i_seq_busy),
  .o_bus_ack(o_bus_ack), .o_bus_rdata(o_bus_rdata), .o_cmd_lock(o_cmd_lock),
  .o_bc_error(o_bc_error), .o_bc_start_addr(o_bc_start_addr), .o_bc_end_addr(o_bc_end_addr),
  .o_bc_descending(o_bc_descending), .o_ecc_buffer_full(o_ecc_buffer_full),
  .o_ecc_word(o_ecc_word));

//--- verif/host_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Register bus master
// ---------------------------------------------------------------------------
module host_model (
  input  wire logic                i_core_clk,
  input  wire logic                i_bus_ack,
  input  wire logic [31:0]         i_bus_rdata,
  output flash_seq_pkg::bus_req_t  o_bus,
  output logic                     o_hung
);
  import flash_seq_pkg::*;
  initial begin
    o_bus = '0;
    o_hung = 1'b0;
  end
  // Released fields show the inverse so stale values cannot pass as held ones.
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    int n;
    @(negedge i_core_clk);
    o_bus = '{req: 1'b1, wr: wr, addr: a, wdata: d};
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (i_bus_ack !== 1'b1 && n < 500);
    if (n >= 500) o_hung = 1'b1;
    rd = i_bus_rdata;
    o_bus = '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : host_model

//--- verif/tb_flash_blank_check_addr_status.sv
`timescale 1ns/1ns
module tb_flash_blank_check_addr_status;
  import flash_seq_pkg::*;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_t;
  logic clk, rst_n, busy, ack, lock, err, desc, full, done_w;
  logic [31:0] rdata, sa, ea, ew, d;
  bus_req_t bus;
  seq_evt_t evt;
  int err_total, checks_done;
  row_t rows [0:4] = '{'{REG_START_ADDR, 32'hffff_ffff, 32'hffff_ffff},
    '{REG_END_ADDR, 32'ha5a5_5a5a, 32'ha5a5_5a5a}, '{4'h7, 32'h1234_5678, 32'h0},
    '{REG_STATUS, 32'hffff_ffff, 32'h0000_8000}, '{REG_SETUP_INIT, 32'h0, 32'h0}};
  flash_blank_check_addr_status flash_blank_check_addr_status_inst (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_bus(bus), .i_evt(evt), .i_seq_busy(busy), .o_bus_ack(ack),
    .o_bus_rdata(rdata), .o_cmd_lock(lock), .o_bc_error(err), .o_bc_start_addr(sa),
    .o_bc_end_addr(ea), .o_bc_descending(desc), .o_ecc_buffer_full(full), .o_ecc_word(ew));
  host_model host_model_inst (.i_core_clk(clk), .i_bus_ack(ack), .i_bus_rdata(rdata),
    .o_bus(bus), .o_hung());
  always #4 clk = ~clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] t;
    host_model_inst.xfer(1'b1, a, v, t);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    host_model_inst.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  // Pulses one event cycle and keeps the command-group level as it stands.
  task automatic pulse(input logic [7:0] e);
    @(negedge clk);
    evt = e | {6'h00, evt.otp_cmd, 1'b0};
    @(negedge clk);
    evt = {6'h00, evt.otp_cmd, 1'b0};
  endtask : pulse
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    #40000;
    err_total++;
    conclude();
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; busy = 1'b0; evt = '0; done_w = 1'b0;
    err_total = 0; checks_done = 0;
    repeat (12) @(negedge clk);
    chk("lock_rst", 32'h0, {31'h0, lock});
    rst_n = 1'b1;
    rd(REG_END_ADDR);
    chk("end_rst", 32'h0, d);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      chk("row", rows[i].exp, d);
    end
    wr(REG_START_ADDR, 32'hfff8_0003);
    wr(REG_END_ADDR, 32'h0000_0004);
    wr(REG_BC_CTRL, 32'h0);
    pulse(8'h80);
    chk("bc_err_up", 32'h0, {31'h0, err});
    chk("end_used", 32'h4, ea);
    chk("start_used", 32'h0, sa);
    wr(REG_BC_CTRL, 32'h1);
    pulse(8'h80);
    chk("bc_err_down", 32'h1, {31'h0, err});
    chk("lock_bc", 32'h1, {31'h0, lock});
    chk("desc_pin", 32'h1, {31'h0, desc});
    pulse(8'h40);
    chk("lock_sc", 32'h0, {31'h0, lock});
    wr(REG_START_ADDR, 32'h0000_0004);
    pulse(8'h80);
    chk("bc_equal", 32'h0, {31'h0, err});
    wr(REG_SETUP_INIT, 32'h1);
    rd(REG_END_ADDR);
    chk("end_init", 32'h0, d);
    rd(REG_START_ADDR);
    chk("start_init", 32'h0, d);
    evt.otp_cmd = 1'b1;
    pulse(8'h14);
    rd(REG_STATUS);
    chk("otp_single", 32'h0001_0000, d & 32'h0003_0000);
    chk("lock_single", 32'h0, {31'h0, lock});
    evt.otp_cmd = 1'b0;
    pulse(8'h18);
    repeat (2) @(negedge clk);
    chk("lock_no_cmd", 32'h0, {31'h0, lock});
    evt.otp_cmd = 1'b1;
    pulse(8'h18);
    @(negedge clk);
    chk("lock_double", 32'h1, {31'h0, lock});
    rd(REG_STATUS);
    chk("otp_both", 32'h0003_0000, d & 32'h0003_0000);
    pulse(8'h20);
    rd(REG_STATUS);
    chk("otp_fs", 32'h0, d & 32'h0003_0000);
    chk("lock_fs", 32'h0, {31'h0, lock});
    evt.otp_cmd = 1'b0;
    wr(REG_ECC_TEST, 32'h1);
    wr(REG_DUMMY_ECC, 32'h0000_005a);
    @(negedge clk);
    chk("ecc_word", 32'h0000_005a, ew);
    chk("ecc_full_pin", 32'h1, {31'h0, full});
    rd(REG_STATUS);
    chk("ecc_full", 32'h1, {31'h0, d[18]});
    fork
      begin
        wr(REG_DUMMY_ECC, 32'h0000_00c3);
        done_w = 1'b1;
      end
      begin
        repeat (6) @(negedge clk);
        chk("stall", 32'h0, {31'h0, done_w});
        pulse(8'h01);
      end
    join
    @(negedge clk);
    chk("ecc_word2", 32'h0000_00c3, ew);
    pulse(8'h01);
    rd(REG_STATUS);
    chk("ecc_empty", 32'h0, {31'h0, d[18]});
    busy = 1'b1;
    rd(REG_STATUS);
    chk("ready_busy", 32'h0, {31'h0, d[15]});
    busy = 1'b0;
    chk("hung", 32'h0, {31'h0, host_model_inst.o_hung});
    conclude();
  end
endmodule : tb_flash_blank_check_addr_status
